// ### design/mcb_memory_ctl.sv
/*
 * Memory control end of the CPU memory control bus: takes requests from
 * the data path, runs memory and peripheral references, prefetches and
 * direct transfers between peripheral and memory in both directions, and moves peripheral data to and
 * from the transceiver module over the low shared lines.
 * Assumes every input comes from logic on ref_clk, and that the shared
 * lines are resolved outside from mc_data_oe and the transceiver enable.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mcb_consts.svh"

module mcb_memory_ctl (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [`MCB_DATA_W-1:0] mc_data_in,
    output logic [`MCB_DATA_W-1:0] mc_data_out,
    output logic mc_data_oe,
    input wire logic memory_req,
    input wire logic [1:0] access_mode_field,
    input wire logic [1:0] data_type,
    input wire logic legacy_isa_active,
    input wire logic [`MCB_FUNC_W-1:0] mem_function_lines,
    input wire logic data_req,
    input wire logic data_phase_done,
    output logic cpu_grant_n,
    output logic memory_busy,
    output logic gate_dir,
    output logic prefetch_buffer_load,
    output logic error_summary_n,
    output logic [`MCB_ERR_W-1:0] err_status,
    input wire logic [`MCB_EXT_ERR_W-1:0] err_event,
    input wire logic [`MCB_ERR_W-1:0] err_clear,
    output logic [`MCB_DATA_W-1:0] ref_addr,
    output logic [1:0] ref_mode,
    output logic ref_legacy,
    output logic xcvr_drive,
    output logic xcvr_load,
    output logic periph_req,
    output logic periph_write,
    input wire logic periph_ack,
    input wire logic direct_transfer_request,
    input wire logic direct_to_mem,
    input wire logic [`MCB_DATA_W-1:0] direct_addr,
    output logic direct_done,
    output logic mem_req,
    output logic mem_write,
    output logic [`MCB_DATA_W-1:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic mem_ack,
    input wire logic [`MCB_DATA_W-1:0] mem_rdata
);

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    function automatic mcb_pkg::mcb_op_t decode_func(input logic [`MCB_FUNC_W-1:0] fn);
        mcb_pkg::mcb_op_t op;
        op.write = fn[`MCB_FN_WRITE];
        op.periph = fn[`MCB_FN_PERIPH];
        op.prefetch = fn[`MCB_FN_PREFETCH] & ~fn[`MCB_FN_WRITE];
        op.direct = 1'b0;
        return op;
    endfunction : decode_func

    // data comes in from the transceivers on peripheral reads and direct-in
    function automatic logic xcvr_inbound(input mcb_pkg::mcb_op_t op);
        return op.direct ? op.write : ~op.write;
    endfunction : xcvr_inbound

    function automatic logic [3:0] byte_enables(input logic [1:0] dt, input logic [1:0] off);
        logic [3:0] be;
        unique case (dt)
            2'h0: be = 4'(4'h1 << off);
            2'h1: be = 4'(4'h3 << off);
            default: be = 4'hF;
        endcase
        return be;
    endfunction : byte_enables

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    mcb_pkg::mcb_state_t state_q;
    mcb_pkg::mcb_state_t state_d;
    mcb_pkg::mcb_op_t op_q;
    mcb_pkg::mcb_op_t op_d;
    mcb_pkg::mcb_op_t op_nx;
    logic [`MCB_DATA_W-1:0] data_q;
    logic [`MCB_DATA_W-1:0] data_d;
    logic dreq_q;
    logic back_ack;
    logic accept;
    logic [`MCB_DATA_W-1:0] rot_in;
    logic [`MCB_DATA_W-1:0] rot_out;
    logic [1:0] rot_off;
    logic rot_left;
    logic [`MCB_ERR_W-1:0] err_d;

    assign back_ack = op_q.periph ? periph_ack : mem_ack;
    assign accept = (state_q == mcb_pkg::MCB_ST_IDLE) && (state_d != mcb_pkg::MCB_ST_IDLE);
    assign op_nx = (state_q == mcb_pkg::MCB_ST_IDLE) ? op_d : op_q;

    always_comb begin
        if (direct_transfer_request) begin
            op_d = '0;
            op_d.direct = 1'b1;
            op_d.write = direct_to_mem;
        end else begin
            op_d = decode_func(mem_function_lines);
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            mcb_pkg::MCB_ST_IDLE: begin
                // direct transfers win over a simultaneous cpu request
                if (direct_transfer_request) begin
                    state_d = direct_to_mem ? mcb_pkg::MCB_ST_XCVR : mcb_pkg::MCB_ST_FETCH;
                end else if (memory_req) begin
                    state_d = op_d.write ? mcb_pkg::MCB_ST_WAIT_REQ : mcb_pkg::MCB_ST_FETCH;
                end
            end
            mcb_pkg::MCB_ST_FETCH: begin
                if (back_ack) begin
                    if (op_q.prefetch) begin
                        state_d = mcb_pkg::MCB_ST_PREF;
                    end else if (op_q.periph || op_q.direct) begin
                        state_d = mcb_pkg::MCB_ST_XCVR;
                    end else begin
                        state_d = mcb_pkg::MCB_ST_WAIT_REQ;
                    end
                end
            end
            mcb_pkg::MCB_ST_WAIT_REQ: begin
                if (dreq_q || data_req) begin
                    state_d = mcb_pkg::MCB_ST_MOVE;
                end
            end
            mcb_pkg::MCB_ST_MOVE: begin
                if (data_phase_done) begin
                    if (!op_q.write) begin
                        state_d = mcb_pkg::MCB_ST_IDLE;
                    end else begin
                        state_d = op_q.periph ? mcb_pkg::MCB_ST_XCVR : mcb_pkg::MCB_ST_STORE;
                    end
                end
            end
            mcb_pkg::MCB_ST_XCVR: begin
                if (xcvr_inbound(op_q)) begin
                    state_d = op_q.direct ? mcb_pkg::MCB_ST_STORE : mcb_pkg::MCB_ST_WAIT_REQ;
                end else begin
                    state_d = op_q.direct ? mcb_pkg::MCB_ST_IDLE : mcb_pkg::MCB_ST_STORE;
                end
            end
            mcb_pkg::MCB_ST_STORE: begin
                if (back_ack) begin
                    state_d = mcb_pkg::MCB_ST_IDLE;
                end
            end
            mcb_pkg::MCB_ST_PREF: state_d = mcb_pkg::MCB_ST_IDLE;
            default: state_d = mcb_pkg::MCB_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= mcb_pkg::MCB_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // a data request may come before read data is back; keep it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dreq_q <= 1'b0;
        end else begin
            dreq_q <= (state_q != mcb_pkg::MCB_ST_IDLE) && (data_req || dreq_q)
                && (state_d != mcb_pkg::MCB_ST_MOVE) && (state_d != mcb_pkg::MCB_ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // reference capture
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            op_q <= '0;
            ref_addr <= '0;
            ref_mode <= 2'h0;
            ref_legacy <= 1'b0;
            mem_be <= `MCB_RST_BE;
        end else if (accept) begin
            op_q <= op_d;
            ref_addr <= op_d.direct ? direct_addr : mc_data_in;
            ref_mode <= op_d.direct ? 2'h0 : access_mode_field;
            ref_legacy <= op_d.direct ? 1'b0 : legacy_isa_active;
            mem_be <= (op_d.direct || op_d.prefetch) ? 4'hF : byte_enables(data_type, mc_data_in[1:0]);
        end
    end

    // ------------------------------------------------------------------
    // data rotator and data register
    // ------------------------------------------------------------------
    always_comb begin
        rot_left = (state_q == mcb_pkg::MCB_ST_MOVE);
        if (op_q.direct || op_q.prefetch) begin
            rot_off = 2'h0;
        end else if (op_q.periph) begin
            rot_off = {1'b0, ref_addr[0]};
        end else begin
            rot_off = ref_addr[1:0];
        end
        unique case (state_q)
            mcb_pkg::MCB_ST_XCVR: rot_in = {{(`MCB_DATA_W-`MCB_PERIPH_W){1'b0}}, mc_data_in[`MCB_PERIPH_W-1:0]};
            mcb_pkg::MCB_ST_MOVE: rot_in = mc_data_in;
            default: rot_in = mem_rdata;
        endcase
    end

    mcb_rotator u_rotator (
        .rot_in(rot_in),
        .rot_off(rot_off),
        .rot_left(rot_left),
        .rot_out(rot_out)
    );

    always_comb begin
        data_d = data_q;
        if (state_q == mcb_pkg::MCB_ST_FETCH && mem_ack && !op_q.periph) begin
            data_d = rot_out;
        end else if (state_q == mcb_pkg::MCB_ST_XCVR && xcvr_inbound(op_q)) begin
            data_d = rot_out;
        end else if (state_q == mcb_pkg::MCB_ST_MOVE && data_phase_done && op_q.write) begin
            data_d = rot_out;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_q <= '0;
            mem_wdata <= '0;
        end else begin
            data_q <= data_d;
            mem_wdata <= data_d;
        end
    end

    // ------------------------------------------------------------------
    // shared line drive
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mc_data_oe <= 1'b0;
            mc_data_out <= '0;
            prefetch_buffer_load <= 1'b0;
            xcvr_drive <= 1'b0;
            xcvr_load <= 1'b0;
        end else begin
            // memory traffic leaves data on the lines for the transceivers only in a direct transfer to the peripheral
            mc_data_oe <= (state_d == mcb_pkg::MCB_ST_MOVE && !op_nx.write)
                || (state_d == mcb_pkg::MCB_ST_PREF)
                || (state_d == mcb_pkg::MCB_ST_XCVR && !xcvr_inbound(op_nx));
            if (state_d == mcb_pkg::MCB_ST_XCVR) begin
                mc_data_out <= {{(`MCB_DATA_W-`MCB_PERIPH_W){1'b0}}, data_d[`MCB_PERIPH_W-1:0]};
            end else begin
                mc_data_out <= data_d;
            end
            prefetch_buffer_load <= (state_d == mcb_pkg::MCB_ST_PREF);
            xcvr_drive <= (state_d == mcb_pkg::MCB_ST_XCVR) && xcvr_inbound(op_nx);
            xcvr_load <= (state_d == mcb_pkg::MCB_ST_XCVR) && !xcvr_inbound(op_nx);
        end
    end

    // ------------------------------------------------------------------
    // handshake outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_grant_n <= `MCB_RST_GRANT_N;
            memory_busy <= 1'b0;
            gate_dir <= `MCB_RST_GATE_DIR;
            direct_done <= 1'b0;
        end else begin
            cpu_grant_n <= !(accept && !op_d.direct);
            memory_busy <= (state_d != mcb_pkg::MCB_ST_IDLE);
            gate_dir <= !((state_d != mcb_pkg::MCB_ST_IDLE) && !op_nx.write && !op_nx.direct);
            direct_done <= op_q.direct && (state_q != mcb_pkg::MCB_ST_IDLE)
                && (state_d == mcb_pkg::MCB_ST_IDLE);
        end
    end

    // back-end requests fall in the same edge as the acknowledge leaves the state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            periph_req <= 1'b0;
            periph_write <= 1'b0;
        end else begin
            mem_req <= (state_d == mcb_pkg::MCB_ST_FETCH || state_d == mcb_pkg::MCB_ST_STORE) && !op_nx.periph;
            mem_write <= (state_d == mcb_pkg::MCB_ST_STORE) && !op_nx.periph;
            periph_req <= (state_d == mcb_pkg::MCB_ST_FETCH || state_d == mcb_pkg::MCB_ST_STORE) && op_nx.periph;
            periph_write <= (state_d == mcb_pkg::MCB_ST_STORE) && op_nx.periph;
        end
    end

    // ------------------------------------------------------------------
    // error summary
    // ------------------------------------------------------------------
    // a new event in the clearing cycle keeps its bit set
    always_comb begin
        err_d = err_status & ~err_clear;
        err_d[`MCB_EXT_ERR_W-1:0] = err_d[`MCB_EXT_ERR_W-1:0] | err_event;
        if (accept && !op_d.direct && data_type == mcb_pkg::MCB_DT_NONE) begin
            err_d[`MCB_ERR_BAD_TYPE] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            err_status <= '0;
            error_summary_n <= `MCB_RST_ERR_N;
        end else begin
            err_status <= err_d;
            error_summary_n <= ~(|err_d);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_grant_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !cpu_grant_n |=> cpu_grant_n && memory_busy)
        else $error("grant not a single cycle with busy held");

    a_busy_state: assert property (@(posedge ref_clk) disable iff (!reset_n)
        memory_busy == (state_q != mcb_pkg::MCB_ST_IDLE))
        else $error("busy disagrees with sequencer");

    a_dir_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (mc_data_oe && !xcvr_load) |-> !gate_dir)
        else $error("direction high while driving data to requester");

    a_dir_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !memory_busy |-> gate_dir)
        else $error("direction low while idle");

    a_pref_strobe: assert property (@(posedge ref_clk) disable iff (!reset_n)
        prefetch_buffer_load |-> mc_data_oe ##1 (!prefetch_buffer_load && !memory_busy))
        else $error("buffer load not a one-cycle driven strobe");

    a_err_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (|err_event) |=> !error_summary_n)
        else $error("error event did not raise summary");

    a_xcvr_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        xcvr_load |-> (mc_data_oe && mc_data_out[`MCB_DATA_W-1:`MCB_PERIPH_W] == 16'h0))
        else $error("transceiver data not on low lines");

    a_mem_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (mem_req && !op_q.direct) |-> !xcvr_drive && !xcvr_load)
        else $error("transceiver active during memory reference");

    a_two_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!cpu_grant_n && !op_q.prefetch) |-> !(mc_data_oe && !xcvr_load))
        else $error("data driven in the request cycle");

endmodule : mcb_memory_ctl
`default_nettype wire

// ### design/mcb_consts.svh
/*
 * Constants of the memory control bus responder: widths, function-line
 * bit positions, the responder's own error status bit and reset values.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef MCB_CONSTS_SVH
`define MCB_CONSTS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define MCB_DATA_W 32
`define MCB_PERIPH_W 16
`define MCB_ERR_W 4
`define MCB_EXT_ERR_W 3
`define MCB_FUNC_W 6

// ----------------------------------------------------------------------
// memory function line bit positions
// ----------------------------------------------------------------------
`define MCB_FN_WRITE 0
`define MCB_FN_PERIPH 1
`define MCB_FN_PREFETCH 2

// ----------------------------------------------------------------------
// error status bit fed by the responder itself
// ----------------------------------------------------------------------
`define MCB_ERR_BAD_TYPE 3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MCB_RST_GATE_DIR 1'b1
`define MCB_RST_GRANT_N 1'b1
`define MCB_RST_ERR_N 1'b1
`define MCB_RST_BE 4'h0

`endif

// ### design/mcb_pkg.sv
/*
 * Types of the memory control bus responder: data type and access mode
 * codes, the decoded reference kind and the sequencer states.
 * Assumes nothing of its surroundings.
 */
package mcb_pkg;

    typedef enum logic [1:0] {
        MCB_DT_BYTE = 2'h0,
        MCB_DT_WORD = 2'h1,
        MCB_DT_NONE = 2'h2,
        MCB_DT_LONG = 2'h3
    } mcb_dtype_t;

    typedef enum logic [1:0] {
        MCB_AM_KERNEL = 2'h0,
        MCB_AM_EXEC = 2'h1,
        MCB_AM_SUPER = 2'h2,
        MCB_AM_USER = 2'h3
    } mcb_amode_t;

    typedef struct packed {
        logic write;
        logic periph;
        logic prefetch;
        logic direct;
    } mcb_op_t;

    // gray along idle, fetch, wait, move
    typedef enum logic [2:0] {
        MCB_ST_IDLE = 3'h0,
        MCB_ST_FETCH = 3'h1,
        MCB_ST_WAIT_REQ = 3'h3,
        MCB_ST_MOVE = 3'h2,
        MCB_ST_STORE = 3'h6,
        MCB_ST_XCVR = 3'h7,
        MCB_ST_PREF = 3'h5
    } mcb_state_t;

endpackage : mcb_pkg

// ### design/mcb_rotator.sv
/*
 * Byte rotator that repositions reference data on the shared lines.
 * Assumes the caller gives the byte offset already reduced to the
 * width of the space being addressed; purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mcb_consts.svh"

module mcb_rotator (
    input wire logic [`MCB_DATA_W-1:0] rot_in,
    input wire logic [1:0] rot_off,
    input wire logic rot_left,
    output logic [`MCB_DATA_W-1:0] rot_out
);

    // ------------------------------------------------------------------
    // per-byte select
    // ------------------------------------------------------------------
    // right moves the addressed byte down to lane 0, left puts it back
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_lane
            logic [1:0] src;
            assign src = rot_left ? (2'(i) - rot_off) : (2'(i) + rot_off);
            assign rot_out[8*i +: 8] = rot_in[8*src +: 8];
        end
    endgenerate

endmodule : mcb_rotator
`default_nettype wire

// ### sim/cmcb_far_model.sv
/*
 * Far-side model of the responder: fixed-word memory, peripheral bus and
 * transceiver, plus resolution of the shared lines.
 * Assumes the bench drives the requester's share of the lines.
 */
`timescale 1ns/10ps
`default_nettype none

module cmcb_far_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic periph_req,
    input wire logic xcvr_drive,
    input wire logic xcvr_load,
    input wire logic mc_data_oe,
    input wire logic dap_on,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mc_data_out,
    input wire logic [31:0] dap_data,
    output logic mem_ack,
    output logic periph_ack,
    output logic [31:0] mem_rdata,
    output logic [31:0] mc_data_in,
    output logic [31:0] last_wr,
    output logic [15:0] last_x
);
    localparam logic [31:0] MEM_WORD = 32'hA1B2C3D4;
    localparam logic [15:0] XDATA = 16'h5A3C;
    logic [2:0] cnt;
    logic [31:0] prev;

    // --------------------------------------------------------------
    // shared lines: undriven lines show the inverse of the last value
    // --------------------------------------------------------------
    always_comb begin
        if (mc_data_oe) begin
            mc_data_in = mc_data_out;
        end else if (xcvr_drive) begin
            mc_data_in = {~prev[31:16], XDATA};
        end else if (dap_on) begin
            mc_data_in = dap_data;
        end else begin
            mc_data_in = ~prev;
        end
    end
    assign mem_rdata = mem_ack ? MEM_WORD : ~MEM_WORD;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 3'h0;
            mem_ack <= 1'b0;
            periph_ack <= 1'b0;
            prev <= 32'h0;
            last_wr <= 32'h0;
            last_x <= 16'h0;
        end else begin
            prev <= mc_data_in;
            if ((mem_req || periph_req) && !(mem_ack || periph_ack)) begin
                // slow answers stretch the wait to five cycles
                if (cnt == (slow ? 3'h4 : 3'h0)) begin
                    mem_ack <= mem_req;
                    periph_ack <= periph_req;
                    cnt <= 3'h0;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end else begin
                mem_ack <= 1'b0;
                periph_ack <= 1'b0;
                cnt <= 3'h0;
            end
            if (mem_ack && mem_write) begin
                last_wr <= mem_wdata;
            end
            if (xcvr_load) begin
                last_x <= mc_data_in[15:0];
            end
        end
    end
endmodule : cmcb_far_model

`default_nettype wire

// ### sim/cpu_memory_control_bus_tb.sv
/*
 * Self-checking bench of the memory control responder.
 * Assumes the far-side model answers memory and peripheral requests.
 */
`timescale 1ns/10ps
`default_nettype none

module cpu_memory_control_bus_tb;
    localparam logic [31:0] MEM_WORD = 32'hA1B2C3D4;
    logic ref_clk, reset_n, memory_req, legacy_isa_active, data_req, data_phase_done, slow, dap_on;
    logic direct_transfer_request, direct_to_mem, mc_data_oe, cpu_grant_n, memory_busy, gate_dir;
    logic prefetch_buffer_load, error_summary_n, ref_legacy, xcvr_drive, xcvr_load, periph_req;
    logic periph_write, periph_ack, direct_done, mem_req, mem_write, mem_ack;
    logic [1:0] access_mode_field, data_type, ref_mode;
    logic [5:0] mem_function_lines;
    logic [2:0] err_event;
    logic [3:0] err_clear, err_status, mem_be;
    logic [31:0] dap_data, direct_addr, mc_data_in, mc_data_out, ref_addr, mem_wdata, mem_rdata, last_wr;
    logic [15:0] last_x;
    int n_fail, cmp_count;

    mcb_memory_ctl u_mcb_memory_ctl (.*);
    cmcb_far_model u_cmcb_far_model (.*);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    // k: 0 data driven, 1 idle, 2 buffer load, 3 direct done, 4 busy
    task automatic wait_for(input int k);
        logic hit;
        for (int i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            #1;
            hit = (k == 0) ? mc_data_oe : (k == 1) ? !memory_busy : (k == 2) ? prefetch_buffer_load :
                  (k == 3) ? direct_done : memory_busy;
            if (hit === 1'b1) return;
        end
        n_fail++;
        $display("[FAIL] %0t wait %0d timed out", $time, k);
        final_report;
    endtask : wait_for

    task automatic start_ref(input logic [31:0] a, input logic [5:0] fn, input logic [1:0] dt,
                             input logic [1:0] md, input logic lg, input logic dir);
        @(posedge ref_clk);
        memory_req <= 1'b1;
        dap_data <= a;
        dap_on <= 1'b1;
        mem_function_lines <= fn;
        data_type <= dt;
        access_mode_field <= md;
        legacy_isa_active <= lg;
        @(posedge ref_clk);
        memory_req <= 1'b0;
        dap_on <= 1'b0;
        #1;
        check(cpu_grant_n, 0, "grant");
        check(memory_busy, 1, "busy");
        check(gate_dir, dir, "direction");
        check(ref_addr, a, "address");
        check({ref_legacy, ref_mode}, {lg, md}, "mode");
        @(posedge ref_clk);
        #1;
        check(cpu_grant_n, 1, "grant pulse");
    endtask : start_ref

    task automatic read_phase(input logic [31:0] exp, input logic [31:0] mask);
        @(posedge ref_clk);
        data_req <= 1'b1;
        wait_for(0);
        check(mc_data_out & mask, exp, "read data");
        check(gate_dir, 0, "read direction");
        @(posedge ref_clk);
        data_phase_done <= 1'b1;
        data_req <= 1'b0;
        @(posedge ref_clk);
        data_phase_done <= 1'b0;
        #1;
        check({memory_busy, gate_dir}, 2'b01, "end of read");
    endtask : read_phase

    task automatic write_phase(input logic [31:0] w);
        @(posedge ref_clk);
        data_req <= 1'b1;
        dap_data <= w;
        dap_on <= 1'b1;
        @(posedge ref_clk);
        data_phase_done <= 1'b1;
        @(posedge ref_clk);
        data_phase_done <= 1'b0;
        data_req <= 1'b0;
        dap_on <= 1'b0;
        wait_for(1);
    endtask : write_phase

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset;
        check({cpu_grant_n, memory_busy, gate_dir, prefetch_buffer_load}, 4'hA, "reset strobes");
        check({error_summary_n, mc_data_oe, mem_req}, 3'h4, "reset idle");
    endtask : t_reset

    task automatic t_mem_read;
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            start_ref(32'h0000_1000 + 32'(i * 4), 6'h00, 2'h3, i[1:0], i[1], 1'b0);
            read_phase(MEM_WORD, 32'hFFFF_FFFF);
        end
        start_ref(32'h0000_100D, 6'h00, 2'h0, 2'h0, 1'b0, 1'b0);
        check(mem_be, 4'h2, "byte enables");
        read_phase(32'h0000_00C3, 32'h0000_00FF);
    endtask : t_mem_read

    task automatic t_prefetch;
        start_ref(32'h0000_0040, 6'h04, 2'h3, 2'h0, 1'b0, 1'b0);
        wait_for(2);
        check(mc_data_out, MEM_WORD, "prefetch data");
        check(gate_dir, 0, "prefetch direction");
        @(posedge ref_clk);
        #1;
        check(prefetch_buffer_load, 0, "load pulse");
        wait_for(1);
    endtask : t_prefetch

    task automatic t_writes;
        start_ref(32'h0000_0080, 6'h01, 2'h3, 2'h1, 1'b0, 1'b1);
        write_phase(32'h1357_9BDF);
        check(last_wr, 32'h1357_9BDF, "memory write");
        start_ref(32'h0000_2004, 6'h03, 2'h1, 2'h3, 1'b1, 1'b1);
        write_phase(32'h0000_9F17);
        check(last_x, 16'h9F17, "peripheral write");
        start_ref(32'h0000_2000, 6'h02, 2'h1, 2'h2, 1'b0, 1'b0);
        read_phase(32'h0000_5A3C, 32'h0000_FFFF);
    endtask : t_writes

    task automatic t_direct;
        for (int d = 0; d < 2; d++) begin
            @(posedge ref_clk);
            direct_transfer_request <= 1'b1;
            direct_to_mem <= d[0];
            direct_addr <= 32'h0000_3000;
            wait_for(4);
            @(posedge ref_clk);
            direct_transfer_request <= 1'b0;
            wait_for(3);
            check(d[0] ? last_wr[15:0] : last_x, d[0] ? 16'h5A3C : MEM_WORD[15:0], "direct data");
            wait_for(1);
        end
    endtask : t_direct

    task automatic t_error;
        @(posedge ref_clk);
        err_event <= 3'h2;
        @(posedge ref_clk);
        err_event <= 3'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({error_summary_n, err_status}, 5'h02, "error raised");
        @(posedge ref_clk);
        err_clear <= 4'h2;
        @(posedge ref_clk);
        err_clear <= 4'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(error_summary_n, 1, "error cleared");
    endtask : t_error

    initial begin
        {reset_n, memory_req, legacy_isa_active, data_req, data_phase_done, slow, dap_on} = 7'h0;
        {direct_transfer_request, direct_to_mem, access_mode_field, data_type} = 6'h0;
        {mem_function_lines, err_event, err_clear, dap_data, direct_addr} = 77'h0;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        t_reset;
        t_mem_read;
        t_prefetch;
        t_writes;
        t_direct;
        t_error;
        final_report;
    end
endmodule : cpu_memory_control_bus_tb

`default_nettype wire
